// ===== design/ctc_pkg.sv
/*
  Shared constants for the compare output / Normal / clear-on-match timer:
  register byte offsets, field positions, reset values and mode codes.
  Assumes a 32-bit Avalon-MM register bus with byte addressing.
*/
package ctc_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [5:0] OFS_CONTROL_A = 6'h00;
  localparam logic [5:0] OFS_CONTROL_C = 6'h04;
  localparam logic [5:0] OFS_COUNTER = 6'h08;
  localparam logic [5:0] OFS_COMPARE_A = 6'h0c;
  localparam logic [5:0] OFS_COMPARE_B = 6'h10;
  localparam logic [5:0] OFS_CAPTURE = 6'h14;
  localparam logic [5:0] OFS_FLAGS = 6'h18;
  localparam logic [5:0] OFS_OUT_STATE = 6'h1c;

  // Field positions in timer_control_a
  localparam int COM_A_LSB = 0;
  localparam int COM_B_LSB = 2;
  localparam int WGM_LSB = 4;

  // Field positions in timer_control_c (write-only strobes)
  localparam int FORCE_A_BIT = 0;
  localparam int FORCE_B_BIT = 1;

  // Field positions in timer_flags
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_A_BIT = 1;
  localparam int FLAG_CMP_B_BIT = 2;
  localparam int FLAG_CAP_BIT = 3;

  // Values after reset
  localparam logic [7:0] CONTROL_A_RST = 8'h00;
  localparam logic [15:0] WORD16_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic OUT_STATE_RST = 1'b0;

  // Counter limits
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;

  // Waveform mode select codes handled here
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_CTC_CAP = 4'hc;

  // Compare output mode codes, non-PWM meaning
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef enum logic {BUS_IDLE, BUS_ACK} ctc_bus_e;

endpackage : ctc_pkg

// ===== design/ctc_oc_unit.sv
/*
  One compare output unit: the internal compare output register and the
  port pin override. Assumes match and force are one-cycle pulses on clk_i
  and that port latch and direction bits come from port logic on clk_i.
*/
`timescale 1ns/1ps
module ctc_oc_unit
  import ctc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Control
  input wire logic [1:0] mode_i,
  input wire logic non_pwm_i,
  input wire logic match_i,
  input wire logic force_i,
  // Port side
  input wire logic port_latch_i,
  input wire logic pin_dir_i,
  // Outputs
  output logic oc_o,
  output logic pin_o,
  output logic pin_oe_n_o
);

  logic oc_q;
  logic oc_d;
  logic act;

  function automatic logic apply_mode(input logic [1:0] m, input logic cur);
    case (m)
      COM_TOGGLE: apply_mode = ~cur;
      COM_CLEAR: apply_mode = 1'b0;
      COM_SET: apply_mode = 1'b1;
      default: apply_mode = cur;
    endcase
  endfunction : apply_mode

  // PWM shaping is outside this block, so only non-PWM actions apply
  assign act = non_pwm_i && (match_i || force_i);

  // Mode read live at the match, so a fresh write governs the next match
  assign oc_d = act ? apply_mode(mode_i, oc_q) : oc_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      oc_q <= OUT_STATE_RST;
    end else if (ce_i) begin
      oc_q <= oc_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      // Override looks at the mode field only, never the waveform mode
      pin_o <= (|mode_i) ? oc_d : port_latch_i;
      pin_oe_n_o <= ~pin_dir_i;
    end
  end

  assign oc_o = oc_q;

endmodule : ctc_oc_unit

// ===== design/ctc_timer.sv
/*
  16-bit timer core: Normal and clear-on-match counting, two compare
  units with pin override, overflow/compare/capture flags, input capture
  and an Avalon-MM slave with waitrequest. Assumes a prescaled tick on
  clk_i, port latch and direction bits from port logic on clk_i, and an
  asynchronous capture pin.
*/
// What this block does
// - Mode zero leaves output register untouched
// - Reset clears both compare output registers
// - Nonzero mode drives pin from compare output
// - Pin direction still follows port direction bit
// - Override ignores waveform mode select
// - Output register settable before pin enabled
// - Output mode never touches input capture
// - New mode acts from next match
// - Force strobe acts at once, non-PWM
// - Only waveform mode shapes counting
// - Mode picks set, clear or toggle
// - Normal mode counts up and wraps
// - Overflow flag set as counter wraps from max to zero
// - Counter writable any time in Normal
// - Clear-on-match clears after top match
// - Top match sets compare A or capture flag
// - Top unbuffered; missed top wraps via max
// - Toggle inverts output A each match
// - Toggle period follows prescaler and compare A
// - Overflow flag set on max to zero
// - Match sets compare flag
// - Force updates output, not flag or counter
// - Counter write blocks next tick's matches
`timescale 1ns/1ps
module ctc_timer
  import ctc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic timer_tick_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Capture input pin
  input wire logic capture_pin_i,
  // Port side, bit 0 unit A, bit 1 unit B
  input wire logic [1:0] port_latch_i,
  input wire logic [1:0] pin_dir_i,
  output logic [1:0] pin_o,
  output logic [1:0] pin_oe_n_o,
  output logic [1:0] compare_output_o
);

  ctc_bus_e bus_q;
  logic waitrequest_q;
  logic [31:0] readdata_q;
  logic [31:0] rd_word;
  logic wr_en;

  logic [7:0] timer_control_a_q;
  logic [15:0] counter_value_q;
  logic [15:0] compare_value_a_q;
  logic [15:0] compare_value_b_q;
  logic [15:0] capture_value_q;
  logic [3:0] timer_flags_q;
  logic [3:0] flags_set;
  logic [3:0] flags_clr;
  logic block_q;

  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [3:0] wgm;
  logic non_pwm;
  logic tick;
  logic wr_counter;
  logic match_a;
  logic match_b;
  logic match_cap;
  logic top_hit;
  logic wrap;
  logic force_a;
  logic force_b;

  logic cap_s1_q;
  logic cap_s2_q;
  logic cap_s3_q;
  logic cap_level_q;
  logic cap_rise;
  logic cap_enable;
  logic [1:0] oc;
  logic [1:0] pin;
  logic [1:0] pin_oe_n;

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  function automatic logic wr_hit(input logic en, input logic [5:0] a,
                                  input logic [5:0] ofs);
    wr_hit = en && (a == ofs);
  endfunction : wr_hit

  assign com_a = timer_control_a_q[COM_A_LSB +: 2];
  assign com_b = timer_control_a_q[COM_B_LSB +: 2];
  assign wgm = timer_control_a_q[WGM_LSB +: 4];
  assign non_pwm = (wgm == WGM_NORMAL) || (wgm == WGM_CTC_A) ||
                   (wgm == WGM_CTC_CAP);

  // Bus slave: one wait cycle, access completes in the ACK cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_q <= BUS_IDLE;
    end else if (ce_i) begin
      case (bus_q)
        BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_q <= BUS_ACK;
          end
        end
        BUS_ACK: bus_q <= BUS_IDLE;
        default: bus_q <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      waitrequest_q <= 1'b1;
    end else if (ce_i) begin
      waitrequest_q <= !((bus_q == BUS_IDLE) &&
                         (avs_read_i || avs_write_i));
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_address_i)
      OFS_CONTROL_A: rd_word[7:0] = timer_control_a_q;
      OFS_COUNTER: rd_word[15:0] = counter_value_q;
      OFS_COMPARE_A: rd_word[15:0] = compare_value_a_q;
      OFS_COMPARE_B: rd_word[15:0] = compare_value_b_q;
      OFS_CAPTURE: rd_word[15:0] = capture_value_q;
      OFS_FLAGS: rd_word[3:0] = timer_flags_q;
      OFS_OUT_STATE: rd_word[1:0] = oc;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      readdata_q <= 32'h0000_0000;
    end else if (ce_i && (bus_q == BUS_IDLE) && avs_read_i) begin
      readdata_q <= rd_word;
    end
  end

  assign wr_en = ce_i && (bus_q == BUS_ACK) && avs_write_i;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      timer_control_a_q <= CONTROL_A_RST;
    end else if (wr_hit(wr_en, avs_address_i, OFS_CONTROL_A) &&
                 avs_byteenable_i[0]) begin
      // Takes effect at once; nothing here is double buffered
      timer_control_a_q <= avs_writedata_i[7:0];
    end
  end

  // Force strobes are pulses; control_c reads back as zero
  assign force_a = wr_hit(wr_en, avs_address_i, OFS_CONTROL_C) &&
                   avs_byteenable_i[0] &&
                   avs_writedata_i[FORCE_A_BIT];
  assign force_b = wr_hit(wr_en, avs_address_i, OFS_CONTROL_C) &&
                   avs_byteenable_i[0] &&
                   avs_writedata_i[FORCE_B_BIT];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      compare_value_a_q <= WORD16_RST;
      compare_value_b_q <= WORD16_RST;
    end else if (wr_en) begin
      // Written straight into the compare registers: top is unbuffered
      if (avs_address_i == OFS_COMPARE_A) begin
        compare_value_a_q <= merge16(compare_value_a_q, avs_writedata_i,
                                     avs_byteenable_i);
      end
      if (avs_address_i == OFS_COMPARE_B) begin
        compare_value_b_q <= merge16(compare_value_b_q, avs_writedata_i,
                                     avs_byteenable_i);
      end
    end
  end

  // Counting
  assign tick = ce_i && timer_tick_i;
  assign wr_counter = wr_hit(wr_en, avs_address_i, OFS_COUNTER) &&
                      (|avs_byteenable_i[1:0]);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      block_q <= 1'b0;
    end else if (wr_counter) begin
      // Held even with the timer stopped, until the next tick passes
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // Matches need equality; a top below the count is missed until wrap
  assign match_a = tick && !block_q &&
                   (counter_value_q == compare_value_a_q);
  assign match_b = tick && !block_q &&
                   (counter_value_q == compare_value_b_q);
  assign match_cap = tick && !block_q &&
                     (counter_value_q == capture_value_q);

  // Top source is chosen by the waveform mode field only
  assign top_hit = ((wgm == WGM_CTC_A) && match_a) ||
                   ((wgm == WGM_CTC_CAP) && match_cap);
  assign wrap = tick && !wr_counter &&
                (counter_value_q == COUNT_MAX);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      counter_value_q <= WORD16_RST;
    end else if (wr_counter) begin
      // Software write wins over a same-cycle tick
      counter_value_q <= merge16(counter_value_q, avs_writedata_i,
                                 avs_byteenable_i);
    end else if (tick) begin
      if (top_hit) begin
        counter_value_q <= COUNT_BOTTOM;
      end else begin
        counter_value_q <= counter_value_q + 16'h0001;
      end
    end
  end

  // Capture input: three-stage sync, level moves when stages 2 and 3 agree
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cap_s1_q <= 1'b0;
      cap_s2_q <= 1'b0;
      cap_s3_q <= 1'b0;
    end else if (ce_i) begin
      cap_s1_q <= capture_pin_i;
      cap_s2_q <= cap_s1_q;
      cap_s3_q <= cap_s2_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cap_level_q <= 1'b0;
    end else if (ce_i && (cap_s2_q == cap_s3_q)) begin
      cap_level_q <= cap_s3_q;
    end
  end

  // Capture path sees neither compare output mode field
  assign cap_enable = (wgm != WGM_CTC_CAP);
  assign cap_rise = ce_i && cap_enable && (cap_s2_q == cap_s3_q) &&
                    cap_s3_q && !cap_level_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      capture_value_q <= WORD16_RST;
    end else if (wr_hit(wr_en, avs_address_i, OFS_CAPTURE)) begin
      capture_value_q <= merge16(capture_value_q, avs_writedata_i,
                                 avs_byteenable_i);
    end else if (cap_rise) begin
      capture_value_q <= counter_value_q;
    end
  end

  // Flags: hardware set beats a same-cycle write-one clear
  always_comb begin
    flags_set = 4'h0;
    flags_set[FLAG_OVF_BIT] = wrap;
    flags_set[FLAG_CMP_A_BIT] = match_a;
    flags_set[FLAG_CMP_B_BIT] = match_b;
    flags_set[FLAG_CAP_BIT] = cap_rise ||
                              ((wgm == WGM_CTC_CAP) && match_cap);
  end

  assign flags_clr = (wr_hit(wr_en, avs_address_i, OFS_FLAGS) &&
                      avs_byteenable_i[0]) ? avs_writedata_i[3:0] : 4'h0;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      timer_flags_q <= FLAGS_RST;
    end else if (ce_i) begin
      // Force strobes never reach the flag path
      timer_flags_q <= (timer_flags_q & ~flags_clr) | flags_set;
    end
  end

  // Compare output units; toggle at top 0 gives half the I/O clock
  ctc_oc_unit u_oc_a (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .mode_i(com_a),
    .non_pwm_i(non_pwm),
    .match_i(match_a),
    .force_i(force_a),
    .port_latch_i(port_latch_i[0]),
    .pin_dir_i(pin_dir_i[0]),
    .oc_o(oc[0]),
    .pin_o(pin[0]),
    .pin_oe_n_o(pin_oe_n[0])
  );

  ctc_oc_unit u_oc_b (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .mode_i(com_b),
    .non_pwm_i(non_pwm),
    .match_i(match_b),
    .force_i(force_b),
    .port_latch_i(port_latch_i[1]),
    .pin_dir_i(pin_dir_i[1]),
    .oc_o(oc[1]),
    .pin_o(pin[1]),
    .pin_oe_n_o(pin_oe_n[1])
  );

  assign avs_readdata_o = readdata_q;
  assign avs_waitrequest_o = waitrequest_q;
  assign pin_o = pin;
  assign pin_oe_n_o = pin_oe_n;
  assign compare_output_o = oc;

endmodule : ctc_timer

// ===== tb/ctc_timer_checker.sv
/*
  Port checker for ctc_timer, bound to it below.
  Assumes ce_i mostly high; unit A mode is shadowed from bus writes.
*/
`timescale 1ns/1ps
module ctc_timer_checker
  import ctc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic timer_tick_i,
  // Bus
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Pins
  input wire logic capture_pin_i,
  input wire logic [1:0] port_latch_i,
  input wire logic [1:0] pin_dir_i,
  input wire logic [1:0] pin_o,
  input wire logic [1:0] pin_oe_n_o,
  input wire logic [1:0] compare_output_o
);
  logic wr_ack;
  logic frc_a;
  logic [1:0] mode_a_q;
  assign wr_ack = ce_i && avs_write_i && !avs_waitrequest_o;
  assign frc_a = wr_ack && avs_address_i == OFS_CONTROL_C
                 && avs_writedata_i[FORCE_A_BIT];
  // Shadow taken at the ack edge, as the register itself
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_a_q <= COM_NONE;
    end else if (wr_ack && avs_address_i == OFS_CONTROL_A
                 && avs_byteenable_i[0]) begin
      mode_a_q <= avs_writedata_i[COM_A_LSB +: 2];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_rst_state: assert property ($fell(sys_rst_i) |->
    compare_output_o == 2'h0 && pin_oe_n_o == 2'h3 && avs_waitrequest_o)
    else $error("outputs not at reset state");
  chk_oe_dir: assert property (!$past(sys_rst_i) && $past(ce_i) |->
    pin_oe_n_o == ~$past(pin_dir_i)) else $error("pin enable wrong");
  chk_pin_source: assert property (!$past(sys_rst_i) && $past(ce_i) |->
    pin_o[0] == (($past(mode_a_q) != COM_NONE) ? compare_output_o[0]
    : $past(port_latch_i[0]))) else $error("pin source wrong");
  chk_ack_prompt: assert property ((avs_read_i || avs_write_i) && ce_i
    && avs_waitrequest_o |-> ##[1:2] !avs_waitrequest_o)
    else $error("bus answer late");
  chk_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("ack longer than one cycle");
  chk_out_cause: assert property (!$past(sys_rst_i)
    && $changed(compare_output_o[0]) |-> $past(timer_tick_i && ce_i)
    || $past(frc_a)) else $error("output changed without cause");
  chk_none_hold: assert property (!$past(sys_rst_i)
    && $past(mode_a_q) == COM_NONE |-> $stable(compare_output_o[0]))
    else $error("mode zero changed output");
  chk_set_code: assert property (!$past(sys_rst_i) && $past(mode_a_q)
    == COM_SET && $changed(compare_output_o[0]) |-> compare_output_o[0])
    else $error("set code cleared output");
  chk_clear_code: assert property (!$past(sys_rst_i)
    && $past(mode_a_q) == COM_CLEAR && $changed(compare_output_o[0])
    |-> !compare_output_o[0]) else $error("clear code set output");
  cover property (frc_a);
  cover property (timer_tick_i && mode_a_q == COM_TOGGLE);
  cover property (!pin_oe_n_o[0] && mode_a_q != COM_NONE);
endmodule : ctc_timer_checker

bind ctc_timer ctc_timer_checker ctc_timer_checker_i (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
  .timer_tick_i(timer_tick_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .capture_pin_i(capture_pin_i), .port_latch_i(port_latch_i),
  .pin_dir_i(pin_dir_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
  .compare_output_o(compare_output_o));

// ===== tb/ctc_port_model.sv
/*
  Port pin logic with a weak pull-down load on each pin.
  Assumes the bench sets latch and direction as software would.
*/
`timescale 1ns/1ps
module ctc_port_model (
  // Clock
  input wire logic clk_i,
  // Software settings
  input wire logic [1:0] latch_set_i,
  input wire logic [1:0] dir_set_i,
  // Timer side
  input wire logic [1:0] pin_val_i,
  input wire logic [1:0] pin_oe_n_i,
  output logic [1:0] port_latch_o,
  output logic [1:0] pin_dir_o,
  output logic [1:0] pin_level_o
);
  always_ff @(posedge clk_i) begin
    port_latch_o <= latch_set_i;
    pin_dir_o <= dir_set_i;
  end
  // Released pin falls to the pull-down level
  assign pin_level_o = pin_val_i & ~pin_oe_n_i;
endmodule : ctc_port_model

// ===== tb/testbench.sv
/*
  Self-checking bench for ctc_timer over Avalon-MM.
  Assumes ce_i high throughout; the capture pin is raised once, in Normal mode.
*/
`timescale 1ns/1ps
module testbench;
  import ctc_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic timer_tick_i = 1'b0;
  logic capture_pin = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] latch_set = 2'h0;
  logic [1:0] dir_set = 2'h0;
  logic [1:0] port_latch, pin_dir, pin_o, pin_oe_n_o, co, level;
  int error_cnt = 0;
  int check_count = 0;
  logic [1:0] codes [5] = '{COM_SET, COM_NONE, COM_TOGGLE, COM_TOGGLE,
                            COM_CLEAR};
  logic exp_co [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  ctc_timer ctc_timer_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .timer_tick_i(timer_tick_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .capture_pin_i(capture_pin), .port_latch_i(port_latch),
    .pin_dir_i(pin_dir),
    .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .compare_output_o(co));
  ctc_port_model ctc_port_model_i (.clk_i(clk_i), .latch_set_i(latch_set),
    .dir_set_i(dir_set), .pin_val_i(pin_o), .pin_oe_n_i(pin_oe_n_o),
    .port_latch_o(port_latch), .pin_dir_o(pin_dir), .pin_level_o(level));

  always #5 clk_i = ~clk_i;

  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected pin at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_pin

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    // A hung slave is left to the watchdog
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp_word(q, exp);
  endtask : rd

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      timer_tick_i <= 1'b1;
      @(posedge clk_i);
      timer_tick_i <= 1'b0;
    end
  endtask : ticks

  task automatic pin_is(input logic [1:0] l, input logic [1:0] d,
                        input logic exp);
    latch_set <= l;
    dir_set <= d;
    repeat (4) @(posedge clk_i);
    cmp_pin(level[0], exp);
  endtask : pin_is

  initial begin
    #300000;
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(OFS_CONTROL_A, 32'h0);
    rd(OFS_OUT_STATE, 32'h0);
    wr(6'h20, 32'hffffffff);
    rd(6'h20, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CONTROL_A, {30'h0, codes[i]});
      wr(OFS_CONTROL_C, 32'h1);
      rd(OFS_OUT_STATE, {31'h0, exp_co[i]});
    end
    rd(OFS_FLAGS, 32'h0);
    // Output primed before the pin is made an output
    wr(OFS_CONTROL_A, {30'h0, COM_SET});
    wr(OFS_CONTROL_C, 32'h1);
    pin_is(2'h0, 2'h0, 1'b0);
    pin_is(2'h0, 2'h1, 1'b1);
    wr(OFS_CONTROL_A, 32'h0);
    pin_is(2'h1, 2'h1, 1'b1);
    pin_is(2'h0, 2'h1, 1'b0);
    wr(OFS_CONTROL_A, 32'h13);
    pin_is(2'h0, 2'h1, 1'b1);
    // Normal mode counting, with unit A set to clear on compare match
    wr(OFS_CONTROL_A, 32'h02);
    wr(OFS_COMPARE_B, 32'h8000);
    wr(OFS_COMPARE_A, 32'h5);
    wr(OFS_COUNTER, 32'h3);
    ticks(3);
    rd(OFS_COUNTER, 32'h6);
    rd(OFS_FLAGS, 32'h2);
    wr(OFS_FLAGS, 32'hf);
    wr(OFS_COUNTER, 32'h5);
    ticks(1);
    rd(OFS_FLAGS, 32'h0);
    rd(OFS_COUNTER, 32'h6);
    wr(OFS_COUNTER, 32'hfffe);
    ticks(2);
    rd(OFS_COUNTER, 32'h0);
    rd(OFS_FLAGS, 32'h1);
    wr(OFS_FLAGS, 32'hf);
    rd(OFS_FLAGS, 32'h0);
    // Output cleared, then toggled on compare A with top of two
    wr(OFS_CONTROL_A, 32'h02);
    wr(OFS_CONTROL_C, 32'h1);
    wr(OFS_COMPARE_A, 32'h2);
    wr(OFS_COUNTER, 32'h0);
    wr(OFS_CONTROL_A, 32'h41);
    ticks(3);
    rd(OFS_COUNTER, 32'h0);
    rd(OFS_OUT_STATE, 32'h1);
    rd(OFS_FLAGS, 32'h2);
    ticks(3);
    rd(OFS_OUT_STATE, 32'h0);
    wr(OFS_FLAGS, 32'hf);
    wr(OFS_COUNTER, 32'ha);
    ticks(1);
    rd(OFS_COUNTER, 32'hb);
    wr(OFS_COUNTER, 32'hffff);
    ticks(1);
    rd(OFS_COUNTER, 32'h0);
    rd(OFS_FLAGS, 32'h1);
    wr(OFS_FLAGS, 32'hf);
    // Top from the capture register
    wr(OFS_CAPTURE, 32'h1);
    wr(OFS_CONTROL_A, 32'hc0);
    wr(OFS_COUNTER, 32'h0);
    ticks(3);
    rd(OFS_COUNTER, 32'h1);
    rd(OFS_FLAGS, 32'h8);
    // Capture in Normal mode with a live toggle code on unit A
    wr(OFS_FLAGS, 32'hf);
    wr(OFS_CONTROL_A, 32'h01);
    wr(OFS_COUNTER, 32'h20);
    capture_pin <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd(OFS_CAPTURE, 32'h20);
    rd(OFS_FLAGS, 32'h8);
    rd(OFS_COUNTER, 32'h20);
    // Unit B forced to set, unit A left alone
    wr(OFS_CONTROL_A, 32'h0c);
    wr(OFS_CONTROL_C, 32'h2);
    rd(OFS_OUT_STATE, 32'h2);
    rd(OFS_FLAGS, 32'h8);
    // Second reset in mid-run
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(OFS_OUT_STATE, 32'h0);
    rd(OFS_CONTROL_A, 32'h0);
    end_sim();
  end
endmodule : testbench
